// >>> core/ufthd_defines.svh
// Purpose: Offsets, fields, reset values and timing for the UART aux block
// Assumes: Offsets are register indices; byte address = 4 * (index - base)
// Notes: Only definitions live here
`ifndef UFTHD_DEFINES_SVH
`define UFTHD_DEFINES_SVH

`define UFTHD_BASE 32'h5000_1000
`define UFTHD_IDX_STET 32'h5000_11a0
`define UFTHD_IDX_HTX 32'h5000_11a4
`define UFTHD_IDX_SACK 32'h5000_11a8
`define UFTHD_IDX_DLF 32'h5000_11c0
`define UFTHD_IDX_VERL 32'h5000_11f8
`define UFTHD_IDX_UCVH 32'h5000_11fa
`define UFTHD_IDX_TYPL 32'h5000_11fc
`define UFTHD_IDX_CTRH 32'h5000_11fe
`define UFTHD_IDX_FCTL 32'h5000_1100
`define UFTHD_IDX_DIV 32'h5000_1104
`define UFTHD_IDX_TXD 32'h5000_1108
`define UFTHD_IDX_CTRL 32'h5000_110c
`define UFTHD_IDX_ISTAT 32'h5000_1110
`define UFTHD_IDX_IEN 32'h5000_1114
`define UFTHD_IDX_ICLR 32'h5000_1118
`define UFTHD_IDX_LVL 32'h5000_111c

`define UFTHD_FCTL_FIFO_EN 0
`define UFTHD_FCTL_TET_LSB 4
`define UFTHD_CTRL_PTHRE 0
`define UFTHD_CTRL_DMA 1
`define UFTHD_IRQ_TXE 0
`define UFTHD_IRQ_TXDONE 1

`define UFTHD_TET_EMPTY 2'h0
`define UFTHD_TET_TWO 2'h1
`define UFTHD_TET_QUART 2'h2
`define UFTHD_TET_HALF 2'h3
`define UFTHD_TWO_CHARS 5'h02

`define UFTHD_RESP_OKAY 2'h0
`define UFTHD_RESP_SLVERR 2'h2
`define UFTHD_RST_ZERO 32'h0000_0000
`define UFTHD_OVERSAMPLE 4'hf
`define UFTHD_LAST_BIT 3'h7
`define UFTHD_FRAC_DIV 16

`endif

// >>> core/ufthd_pkg.sv
// Purpose: Types shared by the UART aux block
// Assumes: Nothing beyond the defines header
// Notes: DMA request lines travel together as one struct
package ufthd_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ufthd_tx_e;
    typedef struct packed {
        logic tx_burst;
        logic tx_single;
        logic rx_burst;
        logic rx_single;
    } ufthd_dma_s;
endpackage : ufthd_pkg

// >>> core/ufthd_top.sv
// Purpose: UART aux control: TX threshold, halt, DMA ack, fractional baud
// Assumes: AXI4-Lite slave, single clock, receiver lives outside
// Notes: 8N1 transmitter with a small TX FIFO
//
// Contract
// [RULE1] Threshold mirror writes only FIFO trigger bits
// [RULE2] Trigger codes: empty, two, quarter, half
// [RULE3] Programmable mode raises TX empty event at threshold
// [RULE4] Halt with FIFOs enabled stops sending
// [RULE5] Halt ignored when FIFOs disabled
// [RULE6] DMA ack drops all four request lines
// [RULE7] DMA ack bit clears itself
// [RULE8] Baud divisor gains fraction DLF/16
// [RULE9] FIFO enable falling resets TX/RX FIFOs
// [RULE10] Reserved bits read zero, writes ignored
`timescale 1ns/1ps
`include "ufthd_defines.svh"

module ufthd_top #(
    parameter int ADDR_W = 12,
    parameter int DEPTH_LOG = 4,
    parameter logic [15:0] VERSION_LO = 16'h0a01, // Arbitrary value
    parameter logic [15:0] VERSION_HI = 16'h0b02, // Arbitrary value
    parameter logic [15:0] TYPE_LO = 16'h0c03, // Arbitrary value
    parameter logic [15:0] TYPE_HI = 16'h0d04 // Arbitrary value
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_single_src,
    input wire logic rx_burst_src,
    output ufthd_pkg::ufthd_dma_s dma_req,
    output logic rx_fifo_reset,
    output logic txd,
    output logic irq
);
    import ufthd_pkg::*;

    localparam int DEPTH = 1 << DEPTH_LOG;
    localparam logic [DEPTH_LOG:0] FULL = (DEPTH_LOG+1)'(DEPTH);
    localparam logic [DEPTH_LOG:0] QUART = (DEPTH_LOG+1)'(DEPTH / 4);
    localparam logic [DEPTH_LOG:0] HALF = (DEPTH_LOG+1)'(DEPTH / 2);

    // AXI write side: address and data caught in either order
    logic [ADDR_W-1:0] awaddr_reg;
    logic aw_have_reg, w_have_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [ADDR_W-1:0] araddr_reg;
    logic ar_have_reg;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
    wire rd_go = ar_have_reg && !s_axi_rvalid;
    wire [31:0] w_idx = `UFTHD_BASE + 32'(awaddr_reg[ADDR_W-1:2]);
    wire [31:0] r_idx = `UFTHD_BASE + 32'(araddr_reg[ADDR_W-1:2]);
    wire lane0 = wstrb_reg[0];
    wire lane1 = wstrb_reg[1];

    wire wr_stet = wr_go && lane0 && (w_idx == `UFTHD_IDX_STET);
    wire wr_htx = wr_go && lane0 && (w_idx == `UFTHD_IDX_HTX);
    wire wr_sack = wr_go && lane0 && (w_idx == `UFTHD_IDX_SACK);
    wire wr_dlf = wr_go && lane0 && (w_idx == `UFTHD_IDX_DLF);
    wire wr_fctl = wr_go && lane0 && (w_idx == `UFTHD_IDX_FCTL);
    wire wr_div = wr_go && (w_idx == `UFTHD_IDX_DIV);
    wire wr_txd = wr_go && lane0 && (w_idx == `UFTHD_IDX_TXD);
    wire wr_ctrl = wr_go && lane0 && (w_idx == `UFTHD_IDX_CTRL);
    wire wr_ien = wr_go && lane0 && (w_idx == `UFTHD_IDX_IEN);
    wire wr_iclr = wr_go && lane0 && (w_idx == `UFTHD_IDX_ICLR);
    wire w_hit = (w_idx == `UFTHD_IDX_STET) || (w_idx == `UFTHD_IDX_HTX)
        || (w_idx == `UFTHD_IDX_SACK) || (w_idx == `UFTHD_IDX_DLF)
        || (w_idx == `UFTHD_IDX_FCTL) || (w_idx == `UFTHD_IDX_DIV)
        || (w_idx == `UFTHD_IDX_TXD) || (w_idx == `UFTHD_IDX_CTRL)
        || (w_idx == `UFTHD_IDX_IEN) || (w_idx == `UFTHD_IDX_ICLR);

    // Control registers
    logic fifo_en_reg, halt_reg, pthre_reg, dma_mode_reg;
    logic [1:0] tet_reg;
    logic [3:0] dlf_reg;
    logic [15:0] div_reg;
    logic [1:0] ien_reg, istat_reg;

    wire [7:0] wd = wdata_reg[7:0];
    wire fifo_en_next = wr_fctl ? wd[`UFTHD_FCTL_FIFO_EN] : fifo_en_reg;
    wire fifo_clear = fifo_en_reg && !fifo_en_next; // RULE9

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fifo_en_reg <= 1'b0;
            halt_reg <= 1'b0;
            pthre_reg <= 1'b0;
            dma_mode_reg <= 1'b0;
            tet_reg <= `UFTHD_TET_EMPTY;
            dlf_reg <= 4'h0;
            div_reg <= 16'h0000;
            ien_reg <= 2'h0;
        end else begin
            fifo_en_reg <= fifo_en_next;
            if (wr_stet || wr_fctl) begin
                // Mirror touches only the trigger pair of FIFO control
                tet_reg <= wr_stet ? wd[1:0]
                    : wd[`UFTHD_FCTL_TET_LSB +: 2]; // RULE1 RULE10
            end
            if (wr_htx) begin
                halt_reg <= wd[0]; // RULE10
            end
            if (wr_dlf) begin
                dlf_reg <= wd[3:0]; // RULE10
            end
            if (wr_div && lane0) begin
                div_reg[7:0] <= wd;
            end
            if (wr_div && lane1) begin
                div_reg[15:8] <= wdata_reg[15:8];
            end
            if (wr_ctrl) begin
                pthre_reg <= wd[`UFTHD_CTRL_PTHRE];
                dma_mode_reg <= wd[`UFTHD_CTRL_DMA];
            end
            if (wr_ien) begin
                ien_reg <= wd[1:0];
            end
        end
    end

    // TX FIFO; with FIFOs off it behaves as a single holding slot
    logic [7:0] mem [DEPTH];
    logic [DEPTH_LOG-1:0] wptr_reg, rptr_reg;
    logic [DEPTH_LOG:0] level_reg;
    logic tx_pop;
    wire [DEPTH_LOG:0] cap = fifo_en_reg ? FULL : (DEPTH_LOG+1)'(1);
    wire push = wr_txd && (level_reg < cap);
    wire pop = tx_pop && (level_reg != '0);

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wptr_reg] <= wd;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            level_reg <= '0;
        end else if (fifo_clear) begin
            wptr_reg <= '0; // RULE9
            rptr_reg <= '0;
            level_reg <= '0;
        end else begin
            wptr_reg <= wptr_reg + DEPTH_LOG'(push);
            rptr_reg <= rptr_reg + DEPTH_LOG'(pop);
            level_reg <= level_reg + (DEPTH_LOG+1)'(push)
                - (DEPTH_LOG+1)'(pop);
        end
    end

    // Threshold level from the two-bit trigger
    logic [DEPTH_LOG:0] thr_lvl;
    always_comb begin
        case (tet_reg) // RULE2
            `UFTHD_TET_EMPTY: thr_lvl = '0;
            `UFTHD_TET_TWO: thr_lvl = (DEPTH_LOG+1)'(`UFTHD_TWO_CHARS);
            `UFTHD_TET_QUART: thr_lvl = QUART;
            `UFTHD_TET_HALF: thr_lvl = HALF;
            default: thr_lvl = '0;
        endcase
    end

    wire prog_mode = pthre_reg && fifo_en_reg;
    wire at_thr = prog_mode ? (level_reg <= thr_lvl) : (level_reg == '0);
    logic at_thr_reg;
    wire txe_ev = at_thr && !at_thr_reg; // RULE3

    // Baud: 16x tick, period alternates div and div+1 by DLF/16
    logic [15:0] bcnt_reg;
    logic [3:0] frac_reg;
    logic tick_reg;
    wire [4:0] frac_sum = {1'b0, frac_reg} + {1'b0, dlf_reg};
    wire frac_carry = frac_sum >= 5'(`UFTHD_FRAC_DIV);
    wire baud_on = div_reg != 16'h0000;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bcnt_reg <= 16'h0000;
            frac_reg <= 4'h0;
            tick_reg <= 1'b0;
        end else if (!baud_on) begin
            bcnt_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else if (bcnt_reg == 16'h0000) begin
            // Extra cycle spreads the fraction over 16 periods
            bcnt_reg <= div_reg - 16'(!frac_carry); // RULE8
            frac_reg <= frac_sum[3:0];
            tick_reg <= 1'b1;
        end else begin
            bcnt_reg <= bcnt_reg - 16'h0001;
            tick_reg <= 1'b0;
        end
    end

    // Serialiser
    ufthd_tx_e st_reg;
    logic [3:0] sub_reg;
    logic [2:0] bit_reg;
    logic [7:0] shift_reg;
    logic done_ev;
    wire hold = halt_reg && fifo_en_reg; // RULE4 RULE5
    wire can_start = (level_reg != '0) && !hold && tick_reg;
    wire bit_end = tick_reg && (sub_reg == `UFTHD_OVERSAMPLE);
    assign tx_pop = (st_reg == TX_IDLE) && can_start;
    assign done_ev = (st_reg == TX_STOP) && bit_end;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= TX_IDLE;
            sub_reg <= 4'h0;
            bit_reg <= 3'h0;
            shift_reg <= 8'h00;
            txd <= 1'b1;
        end else begin
            if (tick_reg) begin
                sub_reg <= sub_reg + 4'h1;
            end
            case (st_reg)
                TX_IDLE: begin
                    txd <= 1'b1;
                    if (tx_pop) begin
                        shift_reg <= mem[rptr_reg];
                        sub_reg <= 4'h0;
                        txd <= 1'b0;
                        st_reg <= TX_START;
                    end
                end
                TX_START: if (bit_end) begin
                    txd <= shift_reg[0];
                    bit_reg <= 3'h0;
                    st_reg <= TX_DATA;
                end
                TX_DATA: if (bit_end) begin
                    if (bit_reg == `UFTHD_LAST_BIT) begin
                        txd <= 1'b1;
                        st_reg <= TX_STOP;
                    end else begin
                        txd <= shift_reg[1];
                        shift_reg <= {1'b0, shift_reg[7:1]};
                        bit_reg <= bit_reg + 3'h1;
                    end
                end
                TX_STOP: if (bit_end) begin
                    st_reg <= TX_IDLE;
                end
                default: st_reg <= TX_IDLE;
            endcase
        end
    end

    // DMA requests; a soft ack masks each line until its source drops
    logic [3:0] mask_reg;
    wire tx_single_src = dma_mode_reg && (level_reg < cap);
    wire tx_burst_src = dma_mode_reg && at_thr;
    wire [3:0] src = {tx_burst_src, tx_single_src, rx_burst_src,
        rx_single_src};

    // Sticky status: set wins over clear
    wire [1:0] ev = {done_ev, txe_ev};
    wire [1:0] clr = wr_iclr ? wd[1:0] : 2'h0;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_reg <= 4'h0;
            dma_req <= '0;
            rx_fifo_reset <= 1'b0;
            at_thr_reg <= 1'b1;
            istat_reg <= 2'h0;
            irq <= 1'b0;
        end else begin
            // Write-only pulse; nothing is stored, so it self-clears
            mask_reg <= wr_sack && wd[0] ? src : (mask_reg & src); // RULE7
            dma_req <= (wr_sack && wd[0]) ? '0 : (src & ~mask_reg); // RULE6
            rx_fifo_reset <= fifo_clear; // RULE9
            at_thr_reg <= at_thr;
            istat_reg <= (istat_reg & ~clr) | ev;
            irq <= |(((istat_reg & ~clr) | ev) & ien_reg);
        end
    end

    // Read decode
    logic [31:0] rmux;
    always_comb begin
        case (r_idx)
            `UFTHD_IDX_STET: rmux = {30'h0, tet_reg}; // RULE1 RULE10
            `UFTHD_IDX_HTX: rmux = {31'h0, halt_reg};
            `UFTHD_IDX_DLF: rmux = {28'h0, dlf_reg};
            `UFTHD_IDX_VERL: rmux = {16'h0, VERSION_LO};
            `UFTHD_IDX_UCVH: rmux = {16'h0, VERSION_HI};
            `UFTHD_IDX_TYPL: rmux = {16'h0, TYPE_LO};
            `UFTHD_IDX_CTRH: rmux = {16'h0, TYPE_HI};
            `UFTHD_IDX_FCTL: rmux = {26'h0, tet_reg, 3'h0, fifo_en_reg};
            `UFTHD_IDX_DIV: rmux = {16'h0, div_reg};
            `UFTHD_IDX_CTRL: rmux = {30'h0, dma_mode_reg, pthre_reg};
            `UFTHD_IDX_ISTAT: rmux = {30'h0, istat_reg};
            `UFTHD_IDX_IEN: rmux = {30'h0, ien_reg};
            `UFTHD_IDX_LVL: rmux = 32'(level_reg);
            default: rmux = `UFTHD_RST_ZERO;
        endcase
    end
    wire r_hit = (r_idx == `UFTHD_IDX_STET) || (r_idx == `UFTHD_IDX_HTX)
        || (r_idx == `UFTHD_IDX_DLF) || (r_idx == `UFTHD_IDX_VERL)
        || (r_idx == `UFTHD_IDX_UCVH) || (r_idx == `UFTHD_IDX_TYPL)
        || (r_idx == `UFTHD_IDX_CTRH) || (r_idx == `UFTHD_IDX_FCTL)
        || (r_idx == `UFTHD_IDX_DIV) || (r_idx == `UFTHD_IDX_CTRL)
        || (r_idx == `UFTHD_IDX_ISTAT) || (r_idx == `UFTHD_IDX_IEN)
        || (r_idx == `UFTHD_IDX_LVL);

    // Bus handshakes
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            ar_have_reg <= 1'b0;
            awaddr_reg <= '0;
            araddr_reg <= '0;
            wdata_reg <= `UFTHD_RST_ZERO;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `UFTHD_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `UFTHD_RESP_OKAY;
            s_axi_rdata <= `UFTHD_RST_ZERO;
        end else begin
            s_axi_awready <= !aw_have_reg && !aw_take;
            s_axi_wready <= !w_have_reg && !w_take;
            s_axi_arready <= !ar_have_reg && !ar_take;
            if (aw_take) begin
                awaddr_reg <= s_axi_awaddr;
                aw_have_reg <= 1'b1;
            end
            if (w_take) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                w_have_reg <= 1'b1;
            end
            if (wr_go) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_hit ? `UFTHD_RESP_OKAY
                    : `UFTHD_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (ar_take) begin
                araddr_reg <= s_axi_araddr;
                ar_have_reg <= 1'b1;
            end
            if (rd_go) begin
                ar_have_reg <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rmux;
                s_axi_rresp <= r_hit ? `UFTHD_RESP_OKAY
                    : `UFTHD_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : ufthd_top

// >>> tb/ufthd_monitor.sv
// Purpose: Port checks for the UART aux block
// Assumes: Byte map of the register decoder
// Notes: Probe reads go to 0x680 and 0x004
`timescale 1ns/1ps
module ufthd_monitor #(
    parameter int ADDR_W = 12
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire ufthd_pkg::ufthd_dma_s dma_req,
    input wire logic rx_fifo_reset,
    input wire logic txd
);
    import ufthd_pkg::*;
    logic wt;
    logic rt;
    logic ack;
    assign wt = s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready;
    assign rt = s_axi_arvalid && s_axi_arready;
    assign ack = wt && s_axi_awaddr == 12'h6a0 && s_axi_wdata[0]
        && s_axi_wstrb[0];
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    property p_w_lat; wt |-> ##2 s_axi_bvalid; endproperty
    a_w_lat: assert property (p_w_lat) else $error("late bvalid");
    property p_r_lat; rt |-> ##2 s_axi_rvalid; endproperty
    a_r_lat: assert property (p_r_lat) else $error("late rvalid");
    property p_one_rd; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_one_rd: assert property (p_one_rd) else $error("second read open");
    property p_resv;
        rt && s_axi_araddr == 12'h680 |-> ##2 s_axi_rdata[31:2] == 30'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits set");
    property p_unmap;
        rt && s_axi_araddr == 12'h004 |-> ##2 s_axi_rresp == 2'h2
            && s_axi_rdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_ack; ack |-> ##[1:3] dma_req == 4'h0; endproperty
    a_ack: assert property (p_ack) else $error("dma request kept");
    property p_rxp; rx_fifo_reset |=> !rx_fifo_reset; endproperty
    a_rxp: assert property (p_rxp) else $error("long fifo reset");
    property p_start; $fell(txd) |=> !txd [*8]; endproperty
    a_start: assert property (p_start) else $error("short start");
    cover property (ack);
    cover property (rx_fifo_reset);
    cover property ($fell(txd));
endmodule : ufthd_monitor

bind ufthd_top ufthd_monitor #(.ADDR_W(ADDR_W)) mon (.*);

// >>> tb/ufthd_serial_rx.sv
// Purpose: Remote serial receiver on the far side of txd
// Assumes: 8N1, LSB first, bit length given in clock cycles
// Notes: Samples mid-bit; low_run holds the last low stretch
`timescale 1ns/1ps
module ufthd_serial_rx (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic txd,
    input wire logic [15:0] bit_cyc,
    output logic [7:0] rx_byte,
    output int frames,
    output logic [31:0] low_run
);
    logic [31:0] run_reg;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            run_reg <= 32'h0;
            low_run <= 32'h0;
        end else if (txd === 1'b0) begin
            run_reg <= run_reg + 32'h1;
        end else begin
            if (run_reg != 32'h0) low_run <= run_reg;
            run_reg <= 32'h0;
        end
    end
    initial begin
        frames = 0;
        rx_byte = 8'h0;
        forever begin
            @(posedge core_clk);
            if (arst_n && txd === 1'b0) begin
                repeat (bit_cyc / 2) @(posedge core_clk);
                for (int i = 0; i < 8; i++) begin
                    repeat (bit_cyc) @(posedge core_clk);
                    rx_byte[i] = txd;
                end
                repeat (bit_cyc) @(posedge core_clk);
                // A bad stop bit is not counted
                if (txd === 1'b1) frames++;
            end
        end
    end
endmodule : ufthd_serial_rx

// >>> tb/ufthd_bench.sv
// Purpose: Self-checking bench for the UART aux block
// Assumes: Byte map of the register decoder, depth 16
// Notes: Random data from a fixed xorshift seed
`timescale 1ns/1ps
module ufthd_bench;
    import ufthd_pkg::*;
    localparam logic [15:0] VLO = 16'h5a11; // Arbitrary value
    localparam logic [15:0] THI = 16'h5a44; // Arbitrary value
    logic core_clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, irq;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, txd, rx_fifo_reset;
    logic rx_single_src, rx_burst_src, got;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, v, d, low_run;
    logic [15:0] bit_cyc, div_v;
    logic [3:0] s_axi_wstrb, dlf;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [7:0] rx_byte;
    ufthd_dma_s dma_req;
    int fails, checks, frames, n, resets;
    ufthd_top #(.VERSION_LO(VLO), .TYPE_HI(THI)) dut (.*);
    ufthd_serial_rx far_end (.core_clk(core_clk), .arst_n(arst_n),
        .txd(txd), .bit_cyc(bit_cyc), .rx_byte(rx_byte),
        .frames(frames), .low_run(low_run));
    // Counts receive FIFO reset pulses seen at the pin
    always @(posedge core_clk) begin
        if (rx_fifo_reset === 1'b1) resets++;
    end
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // Sixteen ticks per bit, the fraction adds whole cycles
    function logic [15:0] blen(input logic [15:0] dv, input logic [3:0] f);
        return (dv << 4) + {12'h0, f};
    endfunction : blen
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t word %h expected %h", $time, g, e);
        end
    endtask : chk_word
    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t resp %h expected %h", $time, g, e);
        end
    endtask : chk_resp
    task automatic wr(input logic [11:0] a, input logic [31:0] dt);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dt;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        got = 1'b0;
        while (!got) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                got = 1'b1;
                s_axi_bready <= 1'b0;
                chk_resp(s_axi_bresp, 2'h0);
            end
        end
    endtask : wr
    task automatic rd(input logic [11:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        got = 1'b0;
        while (!got) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                got = 1'b1;
                s_axi_rready <= 1'b0;
                d = s_axi_rdata;
                r = s_axi_rresp;
            end
        end
    endtask : rd
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        chk_resp(r, 2'h0);
        chk_word(d, e);
    endtask : rdc
    task automatic wait_fr(input int t);
        for (int i = 0; i < 9000 && frames < t; i++) @(posedge core_clk);
        chk_word(32'(frames >= t), 32'h1);
    endtask : wait_fr
    task final_report;
        $display("Counts: checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report
    initial begin
        seed = 32'd24712;
        {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, rx_single_src, rx_burst_src} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'hf;
        bit_cyc = 16'h10;
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        rdc(12'h690, 32'h0);
        rdc(12'h700, 32'h0);
        rdc(12'h7e0, {16'h0, VLO});
        rdc(12'h7f8, {16'h0, THI});
        rd(12'h004);
        chk_resp(r, 2'h2);
        $display("Test reset done");
        wr(12'h400, 32'h1);
        for (int c = 0; c < 4; c++) begin
            v = rnd();
            wr(12'h680, {v[31:2], 2'(c)});
            rdc(12'h680, {30'h0, 2'(c)});
            rdc(12'h400, {26'h0, 2'(c), 4'h1});
        end
        for (int k = 0; k < 3; k++) begin
            v = rnd();
            div_v = {14'h0, v[1:0]} + 16'h1;
            dlf = (k == 0) ? 4'hf : v[7:4];
            bit_cyc = blen(div_v, dlf);
            wr(12'h410, {16'h0, div_v});
            wr(12'h700, {v[31:4], dlf});
            rdc(12'h700, {28'h0, dlf});
            n = frames;
            wr(12'h420, 32'h55);
            wait_fr(n + 1);
            chk_word({24'h0, rx_byte}, 32'h55);
            chk_word(low_run, {16'h0, bit_cyc});
        end
        $display("Test baud done");
        wr(12'h690, 32'hffff_ffff);
        rdc(12'h690, 32'h1);
        n = frames;
        for (int i = 0; i < 3; i++) wr(12'h420, rnd() & 32'hff);
        repeat (40 * bit_cyc) @(posedge core_clk);
        chk_word(32'(frames), 32'(n));
        rdc(12'h470, 32'h3);
        wr(12'h400, 32'h0);
        rdc(12'h470, 32'h0);
        chk_word(32'(resets), 32'h1);
        wr(12'h420, 32'ha3);
        wait_fr(n + 1);
        chk_word({24'h0, rx_byte}, 32'ha3);
        $display("Test halt done");
        wr(12'h400, 32'h11);
        wr(12'h430, 32'h1);
        for (int i = 0; i < 5; i++) wr(12'h420, rnd() & 32'hff);
        wr(12'h450, 32'h1);
        wr(12'h460, 32'h3);
        n = frames;
        wr(12'h690, 32'h0);
        wait_fr(n + 1);
        chk_word({31'h0, irq}, 32'h0);
        wait_fr(n + 5);
        // Let the last stop bit end before clearing
        repeat (bit_cyc) @(posedge core_clk);
        chk_word({31'h0, irq}, 32'h1);
        wr(12'h450, 32'h0);
        repeat (2) @(posedge core_clk);
        chk_word({31'h0, irq}, 32'h0);
        wr(12'h460, 32'h3);
        rdc(12'h440, 32'h0);
        $display("Test irq done");
        wr(12'h430, 32'h2);
        for (int j = 0; j < 2; j++) begin
            {rx_single_src, rx_burst_src} <= 2'h3;
            repeat (3) @(posedge core_clk);
            chk_word({28'h0, dma_req} & 32'h3, 32'h3);
            wr(12'h6a0, 32'h1);
            repeat (2) @(posedge core_clk);
            chk_word({28'h0, dma_req}, 32'h0);
            {rx_single_src, rx_burst_src} <= 2'h0;
            @(posedge core_clk);
        end
        $display("Test dma done");
        final_report();
    end
    // Tests need about 7500 cycles; leave ample margin
    initial begin
        repeat (60000) @(posedge core_clk);
        fails++;
        $display("ERROR %0t watchdog expired", $time);
        final_report();
    end
endmodule : ufthd_bench
